// ===== nvsrc_defs.svh
// Constant definitions for the nonvolatile store and recall control block.
`ifndef NVSRC_DEFS_SVH
`define NVSRC_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define NVS_CLK_NS 25
`define NVS_PU_NS 200
`define NVS_PU_CYC ((`NVS_PU_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_RECALL_NS 1500
`define NVS_RECALL_CYC (`NVS_RECALL_NS / `NVS_CLK_NS)
`define NVS_STORE_NS 10000000
`define NVS_STORE_CYC (`NVS_STORE_NS / `NVS_CLK_NS)

// ----------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------
`define NVS_FRAME_BITS 8
`define NVS_START_POS 7
`define NVS_OP_MSB 2
`define NVS_OP_STORE 3'h1
`define NVS_OP_RECALL 3'h5
`define NVS_OP_UNLOCK 3'h4
`define NVS_OP_WRDS 3'h0

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define NVS_OFS_STATUS 8'h00
`define NVS_OFS_CMD 8'h04
`define NVS_OFS_RAM 8'h40
`define NVS_OFS_NV 8'h80
`define NVS_WIN_MASK 8'hc0
`define NVS_ST_PREV 0
`define NVS_ST_WEL 1
`define NVS_ST_STORE 2
`define NVS_ST_RECALL 3
`define NVS_ST_INHIBIT 4
`define NVS_ST_LOW 5

`endif

// ===== nvsrc_pkg.sv
// Types and the instruction decoder shared by the control block.
`include "nvsrc_defs.svh"

package nvsrc_pkg;

	typedef enum logic [3:0] {
		ST_INHIBIT = 4'b0001,
		ST_IDLE = 4'b0010,
		ST_RECALL = 4'b0100,
		ST_STORE = 4'b1000
	} nvsrc_state_t;

	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_STORE,
		CMD_RECALL,
		CMD_UNLOCK,
		CMD_LOCK
	} nvsrc_cmd_t;

	// A frame is a start bit, four ignored bits and a three bit opcode.
	function automatic nvsrc_cmd_t nvsrc_decode(input logic [7:0] frame);
		nvsrc_cmd_t c;
		c = CMD_NONE;
		if (frame[`NVS_START_POS]) begin
			case (frame[`NVS_OP_MSB:0])
				`NVS_OP_STORE: c = CMD_STORE;
				`NVS_OP_RECALL: c = CMD_RECALL;
				`NVS_OP_UNLOCK: c = CMD_UNLOCK;
				`NVS_OP_WRDS: c = CMD_LOCK;
				default: c = CMD_NONE;
			endcase
		end
		return c;
	endfunction : nvsrc_decode

endpackage : nvsrc_pkg

// ===== nvsrc_xfer_if.sv
// Handshake between the controller and the array copy engine.
`timescale 1ns/1ps

interface nvsrc_xfer_if;
	logic start;
	logic to_nv;
	logic busy;
	logic step;
	logic done;
	logic [3:0] idx;

	modport eng (input start, input to_nv, output busy, output step, output done, output idx);
	modport ctl (output start, output to_nv, input busy, input step, input done, input idx);
endinterface : nvsrc_xfer_if

// ===== nvsrc_copy.sv
// Array copy engine: sweeps every word once, then holds busy for the rest of the cycle time.
`timescale 1ns/1ps

module nvsrc_copy import nvsrc_pkg::*; #(
	parameter int WORDS = 16,
	parameter int CNT_W = 20,
	parameter int RECALL_CYC = `NVS_RECALL_CYC,
	parameter int STORE_CYC = `NVS_STORE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	nvsrc_xfer_if.eng xf
);

	logic busy_q;
	logic dir_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] last;

	assign last = dir_q ? CNT_W'(STORE_CYC - 1) : CNT_W'(RECALL_CYC - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			dir_q <= 1'b0;
			cnt_q <= '0;
		end else if (!busy_q) begin
			cnt_q <= '0;
			if (xf.start) begin
				busy_q <= 1'b1;
				dir_q <= xf.to_nv;
			end
		end else if (cnt_q == last) begin
			busy_q <= 1'b0;
		end else begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	assign xf.busy = busy_q;
	assign xf.step = busy_q && (cnt_q < CNT_W'(WORDS));
	assign xf.idx = cnt_q[3:0];
	assign xf.done = busy_q && (cnt_q == last);

endmodule : nvsrc_copy

// ===== nvsrc_ctrl.sv
// Store and recall controller with serial decoder, latches, arrays and APB slave.
`timescale 1ns/1ps

// Behaviour
// - Recall instruction or low recall pin copies the whole nonvolatile array into RAM.
// - RAM writes and stores are refused until a pin or instruction recall has completed.
// - Any pin or instruction recall completion sets the previous-recall latch.
// - After power-up a recall runs by itself with no host action.
// - After power-up all functions are held off for at least 200 ns.
// - Store instruction or low store pin copies the whole RAM into nonvolatile array.
// - A store runs only while the previous-recall latch is set.
// - A store runs only while the write-enable latch is set.
// - While storing, every other function including instructions and pin recalls is ignored.
// - Finishing a store clears the write-enable latch.
// - Supply-low blocks stores and clears the write-enable latch.
// - Store instruction is start bit, four ignored bits, opcode 001.
// - Recall instruction is start bit, four ignored bits, opcode 101.
// - Unlock instruction, opcode 100, sets the write-enable latch.
// - The write-enable latch starts cleared at power-up.
module nvsrc_ctrl import nvsrc_pkg::*; #(
	parameter int WORDS = 16,
	parameter int DW = 16,
	parameter int STORE_CYC = `NVS_STORE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sk,
	input wire logic di,
	input wire logic ce,
	input wire logic recall_n,
	input wire logic store_n,
	input wire logic supply_low,
	output logic store_busy,
	output logic recall_busy
);

	localparam int PU_CYC = `NVS_PU_CYC;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] pin_s1_q;
	logic [5:0] pin_s2_q;
	logic sk_prev_q;
	logic sk_s;
	logic di_s;
	logic ce_s;
	logic recall_pin;
	logic store_pin;
	logic low_s;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q <= 6'h18;
			pin_s2_q <= 6'h18;
			sk_prev_q <= 1'b0;
		end else begin
			pin_s1_q <= {supply_low, store_n, recall_n, ce, di, sk};
			pin_s2_q <= pin_s1_q;
			sk_prev_q <= pin_s2_q[0];
		end
	end

	assign sk_s = pin_s2_q[0];
	assign di_s = pin_s2_q[1];
	assign ce_s = pin_s2_q[2];
	assign recall_pin = !pin_s2_q[3];
	assign store_pin = !pin_s2_q[4];
	assign low_s = pin_s2_q[5];

	// ----------------------------------------------------------------
	// Serial instruction shifter
	// ----------------------------------------------------------------
	logic [7:0] shift_q;
	logic [3:0] nbits_q;
	logic frame_q;
	logic sk_rise;

	assign sk_rise = sk_s && !sk_prev_q;

	// Bits before the start bit are skipped; a deselect clears the frame.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_q <= '0;
			nbits_q <= '0;
			frame_q <= 1'b0;
		end else if (!ce_s) begin
			shift_q <= '0;
			nbits_q <= '0;
			frame_q <= 1'b0;
		end else begin
			frame_q <= 1'b0;
			if (sk_rise && nbits_q < 4'(`NVS_FRAME_BITS) && (nbits_q != 4'h0 || di_s)) begin
				shift_q <= {shift_q[6:0], di_s};
				nbits_q <= nbits_q + 4'h1;
				frame_q <= (nbits_q == 4'(`NVS_FRAME_BITS - 1));
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	logic [DW-1:0] ram_q [WORDS];
	logic [DW-1:0] nv_q [WORDS];
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic setup;
	logic access;
	logic [3:0] widx;
	logic in_ram;
	logic in_nv;
	logic is_stat;
	logic is_cmd;
	logic ram_wr_ok;
	logic apb_ram_wr;
	nvsrc_cmd_t apb_cmd;
	nvsrc_state_t state_q;
	logic prev_q;
	logic wel_q;
	logic [31:0] status;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign widx = paddr[5:2];
	assign in_ram = (paddr & `NVS_WIN_MASK) == `NVS_OFS_RAM && paddr[1:0] == 2'h0;
	assign in_nv = (paddr & `NVS_WIN_MASK) == `NVS_OFS_NV && paddr[1:0] == 2'h0;
	assign is_stat = paddr == `NVS_OFS_STATUS;
	assign is_cmd = paddr == `NVS_OFS_CMD;
	assign ram_wr_ok = prev_q && wel_q && state_q == ST_IDLE;
	assign apb_ram_wr = access && pwrite && in_ram && ram_wr_ok;
	assign apb_cmd = (access && pwrite && is_cmd) ? nvsrc_decode(pwdata[7:0]) : CMD_NONE;
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q && access;

	always_comb begin
		status = '0;
		status[`NVS_ST_PREV] = prev_q;
		status[`NVS_ST_WEL] = wel_q;
		status[`NVS_ST_STORE] = state_q == ST_STORE;
		status[`NVS_ST_RECALL] = state_q == ST_RECALL;
		status[`NVS_ST_INHIBIT] = state_q == ST_INHIBIT;
		status[`NVS_ST_LOW] = low_s;
	end

	// Read data and error are prepared in the setup phase for a zero-wait access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
			if (!pwrite && is_stat) begin
				prdata_q <= status;
			end else if (!pwrite && in_ram) begin
				prdata_q <= 32'(ram_q[widx]);
			end else if (!pwrite && in_nv) begin
				prdata_q <= 32'(nv_q[widx]);
			end else if (pwrite && is_cmd) begin
				pslverr_q <= state_q != ST_IDLE;
			end else if (pwrite && in_ram) begin
				pslverr_q <= !ram_wr_ok;
			end else begin
				pslverr_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Request merge
	// ----------------------------------------------------------------
	nvsrc_cmd_t cmd;
	logic store_req;
	logic store_go;
	logic recall_req;

	assign cmd = frame_q ? nvsrc_decode(shift_q) : apb_cmd;
	assign store_req = cmd == CMD_STORE || store_pin;
	assign store_go = store_req && prev_q && wel_q && !low_s;
	assign recall_req = cmd == CMD_RECALL || recall_pin;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	nvsrc_xfer_if xf ();
	logic [7:0] pu_cnt_q;
	logic recall_user_q;

	nvsrc_copy #(
		.WORDS(WORDS),
		.CNT_W(20),
		.RECALL_CYC(`NVS_RECALL_CYC),
		.STORE_CYC(STORE_CYC)
	) u_copy (
		.pclk(pclk),
		.presetn(presetn),
		.xf(xf)
	);

	assign xf.start = (state_q == ST_IDLE && (store_go || recall_req)) ||
		(state_q == ST_INHIBIT && pu_cnt_q == 8'(PU_CYC - 1));
	assign xf.to_nv = state_q == ST_IDLE && store_go;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pu_cnt_q <= '0;
		end else if (state_q == ST_INHIBIT) begin
			pu_cnt_q <= pu_cnt_q + 8'h1;
		end
	end

	// Store outranks recall; requests in any busy state are dropped.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_INHIBIT;
			recall_user_q <= 1'b0;
		end else begin
			case (state_q)
				ST_INHIBIT: begin
					if (pu_cnt_q == 8'(PU_CYC - 1)) begin
						state_q <= ST_RECALL;
						recall_user_q <= 1'b0;
					end
				end
				ST_IDLE: begin
					if (store_go) begin
						state_q <= ST_STORE;
					end else if (recall_req) begin
						state_q <= ST_RECALL;
						recall_user_q <= 1'b1;
					end
				end
				ST_RECALL: begin
					if (xf.done) begin
						state_q <= ST_IDLE;
					end
				end
				ST_STORE: begin
					if (xf.done) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_INHIBIT;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Latches
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'b0;
		end else if (state_q == ST_RECALL && xf.done && recall_user_q) begin
			prev_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wel_q <= 1'b0;
		end else if (low_s) begin
			wel_q <= 1'b0;
		end else if (state_q == ST_STORE && xf.done) begin
			wel_q <= 1'b0;
		end else if (state_q == ST_IDLE && !store_go && !recall_req) begin
			if (cmd == CMD_UNLOCK) begin
				wel_q <= 1'b1;
			end else if (cmd == CMD_LOCK) begin
				wel_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Arrays
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < WORDS; i++) begin
				ram_q[i] <= '0;
			end
		end else if (xf.step && state_q == ST_RECALL) begin
			ram_q[xf.idx] <= nv_q[xf.idx];
		end else if (apb_ram_wr) begin
			ram_q[widx] <= pwdata[DW-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < WORDS; i++) begin
				nv_q[i] <= '0;
			end
		end else if (xf.step && state_q == ST_STORE) begin
			nv_q[xf.idx] <= ram_q[xf.idx];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_busy <= 1'b0;
			recall_busy <= 1'b0;
		end else begin
			store_busy <= xf.busy && state_q == ST_STORE;
			recall_busy <= xf.busy && state_q == ST_RECALL;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_store_prev_recall: assert property (
		$rose(state_q == ST_STORE) |-> $past(prev_q))
		else $error("store started without previous recall");
	chk_store_unlocked: assert property (
		$rose(state_q == ST_STORE) |-> $past(wel_q))
		else $error("store started with write enable clear");
	chk_store_low_block: assert property (
		low_s |=> !wel_q && !$rose(state_q == ST_STORE))
		else $error("supply low did not block store");
	chk_store_end_lock: assert property (
		$fell(state_q == ST_STORE) |-> !wel_q)
		else $error("write enable survived a store");
	chk_store_exclusive: assert property (
		state_q == ST_STORE && !xf.done |=> state_q == ST_STORE && $stable(prev_q))
		else $error("store was interrupted");
	chk_refused_store: assert property (
		state_q == ST_IDLE && store_req && !store_go && !recall_req |=>
		state_q == ST_IDLE && $stable(prev_q))
		else $error("refused store changed state");
	chk_recall_latch: assert property (
		state_q == ST_RECALL && xf.done && recall_user_q |=> prev_q ##1 prev_q)
		else $error("recall did not set latch");
	chk_ram_gate: assert property (
		apb_ram_wr |-> prev_q && wel_q)
		else $error("RAM written before recall");
	chk_pu_inhibit: assert property (
		$fell(state_q == ST_INHIBIT) |-> $past(pu_cnt_q) == 8'(PU_CYC - 1))
		else $error("power-up inhibit too short");
	chk_auto_recall: assert property (
		$fell(state_q == ST_INHIBIT) |-> state_q == ST_RECALL && !recall_user_q)
		else $error("no recall after power-up");
	chk_recall_start: assert property (
		state_q == ST_IDLE && recall_req && !store_go |=>
		state_q == ST_RECALL ##[1:70] state_q == ST_IDLE)
		else $error("recall request not served");
	chk_unlock_sets: assert property (
		state_q == ST_IDLE && cmd == CMD_UNLOCK && !low_s && !store_go && !recall_req |=> wel_q)
		else $error("unlock did not set write enable");
	chk_store_start: assert property (
		state_q == ST_IDLE && store_go |=> state_q == ST_STORE ##1 store_busy)
		else $error("store request not served");

	cov_store_done: cover property ($fell(state_q == ST_STORE));
	cov_pin_recall: cover property (state_q == ST_IDLE && recall_pin ##1 state_q == ST_RECALL);
	cov_refused: cover property (state_q == ST_IDLE && store_req && !store_go);

endmodule : nvsrc_ctrl

// ===== nvsrc_host.sv
// Host model driving the serial instruction link and the two control pins.
`timescale 1ns/1ps

module nvsrc_host import nvsrc_pkg::*; (
	input wire logic pclk,
	output logic sk,
	output logic di,
	output logic ce,
	output logic recall_n,
	output logic store_n
);
	initial begin
		sk = 1'b0;
		di = 1'b0;
		ce = 1'b0;
		recall_n = 1'b1;
		store_n = 1'b1;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge pclk);
	endtask : hold

	// The clock rests low between frames and released data shows the inverse of its last bit.
	task automatic send_frame(input logic [7:0] f);
		ce <= 1'b1;
		for (int i = 7; i >= 0; i--) begin
			di <= f[i];
			hold(3);
			sk <= 1'b1;
			hold(3);
			sk <= 1'b0;
		end
		hold(3);
		ce <= 1'b0;
		di <= ~f[0];
		hold(1);
	endtask : send_frame

	// Holds one control pin low for n cycles, then releases both.
	task automatic pin_pulse(input bit do_store, input int n);
		if (do_store) store_n <= 1'b0;
		else recall_n <= 1'b0;
		hold(n);
		store_n <= 1'b1;
		recall_n <= 1'b1;
		hold(1);
	endtask : pin_pulse
endmodule : nvsrc_host

// ===== nvram_store_recall_control_test.sv
// Self-checking bench for the store and recall controller.
`timescale 1ns/1ps
`include "nvsrc_defs.svh"

module nvram_store_recall_control_test import nvsrc_pkg::*; ;
	localparam int STORE_CYC = 40;
	logic pclk, presetn, psel, penable, pwrite, supply_low, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic sk, di, ce, recall_n, store_n, store_busy, recall_busy;
	int error_cnt = 0, checked = 0, cyc = 0, n_store = 0, n_recall = 0;
	int ram_m[16], nv_m[16];
	bit prev_m, wel_m;

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	nvsrc_ctrl #(.WORDS(16), .DW(16), .STORE_CYC(STORE_CYC)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sk(sk), .di(di), .ce(ce),
		.recall_n(recall_n), .store_n(store_n), .supply_low(supply_low),
		.store_busy(store_busy), .recall_busy(recall_busy));
	nvsrc_host u_host (.pclk(pclk), .sk(sk), .di(di), .ce(ce), .recall_n(recall_n),
		.store_n(store_n));

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if ($rose(store_busy)) n_store <= n_store + 1;
		if ($rose(recall_busy)) n_recall <= n_recall + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("Mismatches %0d of %0d comparisons", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [7:0] frm(input logic [2:0] op);
		return {1'b1, 4'($urandom), op};
	endfunction : frm

	task automatic chk_st(input string what);
		apb(1'b0, `NVS_OFS_STATUS, 32'h0);
		chk(rd & 32'h3, {30'h0, wel_m, prev_m}, what);
	endtask : chk_st

	task automatic idle();
		int k;
		k = 0;
		do begin
			apb(1'b0, `NVS_OFS_STATUS, 32'h0);
			k++;
		end while (rd[4:2] !== 3'h0 && k < 200);
		if (rd[4:2] !== 3'h0) begin
			error_cnt++;
			final_report();
		end
	endtask : idle

	task automatic fill(input bit ok);
		for (int i = 0; i < 16; i++) begin
			logic [15:0] v;
			v = 16'($urandom);
			apb(1'b1, `NVS_OFS_RAM + 8'(4 * i), {16'h0, v});
			if (ok) ram_m[i] = v;
			chk(err, !ok, "ram write response");
		end
	endtask : fill

	task automatic chk_arr(input logic [7:0] base, input bit nv, input string what);
		for (int i = 0; i < 16; i++) begin
			apb(1'b0, base + 8'(4 * i), 32'h0);
			chk(rd, 32'(nv ? nv_m[i] : ram_m[i]), what);
		end
	endtask : chk_arr

	task automatic model_store();
		foreach (nv_m[i]) nv_m[i] = ram_m[i];
		wel_m = 1'b0;
	endtask : model_store

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		supply_low = 1'b0;
		presetn = 1'b0;
		void'($urandom(32'h9891));
		foreach (ram_m[i]) ram_m[i] = 0;
		foreach (nv_m[i]) nv_m[i] = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `NVS_OFS_STATUS, 32'h0);
		chk(rd[`NVS_ST_INHIBIT], 1'b1, "inhibit after power-up");
		apb(1'b1, `NVS_OFS_CMD, {24'h0, frm(`NVS_OP_RECALL)});
		chk(err, 1'b1, "command during inhibit");
		idle();
		chk(n_recall, 1, "power-on recall");
		chk_st("latches after power-up");
		apb(1'b1, `NVS_OFS_RAM + 8'h0c, 32'h1234);
		chk(err, 1'b1, "ram write before recall");
		apb(1'b0, 8'h3c, 32'h0);
		chk(err, 1'b1, "unmapped read");
		u_host.send_frame(frm(`NVS_OP_UNLOCK));
		wel_m = 1'b1;
		apb(1'b1, `NVS_OFS_CMD, {24'h0, frm(`NVS_OP_STORE)});
		idle();
		chk(n_store, 0, "store without recall");
		chk_st("latches after refused store");
		u_host.send_frame(frm(`NVS_OP_RECALL));
		idle();
		prev_m = 1'b1;
		chk(n_recall, 2, "serial recall");
		chk_st("recall sets latch");
		fill(1'b1);
		u_host.send_frame(frm(`NVS_OP_STORE));
		apb(1'b1, `NVS_OFS_CMD, {24'h0, frm(`NVS_OP_RECALL)});
		chk(err, 1'b1, "command during store");
		u_host.pin_pulse(1'b0, 5);
		idle();
		model_store();
		chk(n_store, 1, "serial store");
		chk(n_recall, 2, "recall during store");
		chk_st("store clears write enable");
		chk_arr(`NVS_OFS_NV, 1'b1, "stored array");
		fill(1'b0);
		u_host.pin_pulse(1'b1, 5);
		idle();
		chk(n_store, 1, "store without enable");
		apb(1'b1, `NVS_OFS_CMD, {24'h0, frm(`NVS_OP_UNLOCK)});
		wel_m = 1'b1;
		chk_st("unlock by register");
		fill(1'b1);
		u_host.pin_pulse(1'b0, 5);
		idle();
		foreach (ram_m[i]) ram_m[i] = nv_m[i];
		chk(n_recall, 3, "pin recall");
		chk_arr(`NVS_OFS_RAM, 1'b0, "recalled array");
		supply_low <= 1'b1;
		wel_m = 1'b0;
		repeat (4) @(posedge pclk);
		chk_st("supply low clears enable");
		u_host.pin_pulse(1'b1, 5);
		idle();
		chk(n_store, 1, "store under supply low");
		supply_low <= 1'b0;
		u_host.send_frame(frm(`NVS_OP_UNLOCK));
		fill(1'b1);
		u_host.pin_pulse(1'b1, 5);
		idle();
		model_store();
		chk(n_store, 2, "pin store");
		chk_st("pin store clears enable");
		chk_arr(`NVS_OFS_NV, 1'b1, "pin stored array");
		u_host.send_frame(frm(`NVS_OP_UNLOCK));
		wel_m = 1'b1;
		chk_st("serial unlock sets enable");
		u_host.send_frame(frm(`NVS_OP_WRDS));
		wel_m = 1'b0;
		chk_st("lock clears enable");
		final_report();
	end
endmodule : nvram_store_recall_control_test
